/* File: hw/spl_stack_check.sv */
// Stack pointer update, push formatting and stack error trap logic.
`timescale 1ns/1ps
`include "spl_consts.svh"
module spl_stack_check
	import spl_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire spl_req_s    i_req,
	input  wire logic        i_pc_push,
	input  wire logic        i_exception,
	input  wire logic [7:0]  i_pc_hi,
	input  wire logic [7:0]  i_status_low_byte,
	input  wire logic        i_lim_wr,
	input  wire logic [15:0] i_lim_data,
	input  wire logic        i_sp_wr,
	input  wire logic [15:0] i_sp_data,
	output logic      [15:0] o_stack_pointer_register,
	output logic      [15:0] o_stack_limit_register,
	output spl_mem_s         o_mem,
	output logic      [15:0] o_push_pc_word,
	output logic             o_trap
);
	logic [15:0] sp_reg;
	logic [15:0] sp_next;
	logic [15:0] lim_reg;
	logic [15:0] lim_next;
	logic        push;
	logic        pop;
	logic        ea_chk;
	logic [15:0] chk_addr;

	function automatic logic [15:0] word_align(input logic [15:0] v);
		word_align = {v[15:1], 1'b0};
	endfunction

	// Word steps are shared by the pointer update and the pop address path.
	function automatic logic [15:0] step_up(input logic [15:0] v);
		step_up = v + `SPL_WORD_STEP;
	endfunction

	function automatic logic [15:0] step_down(input logic [15:0] v);
		step_down = v - `SPL_WORD_STEP;
	endfunction

	// The enable gates every operation, so a frozen cycle neither moves the pointer nor traps.
	assign push = i_ce && i_req.valid && (i_req.op == SPL_OP_PUSH);
	assign pop  = i_ce && i_req.valid && (i_req.op == SPL_OP_POP);
	assign ea_chk = i_ce && i_req.valid && (i_req.op == SPL_OP_EA);

	spl_pc_format u_pc_format (
		.i_pc_hi           (i_pc_hi),
		.i_exception       (i_exception && i_pc_push),
		.i_status_low_byte (i_status_low_byte),
		.o_word            (o_push_pc_word)
	);

	// Pointer update: pop pre-decrements, push post-increments.
	always_comb begin
		sp_next = sp_reg;
		if (i_ce && i_sp_wr) begin
			sp_next = word_align(i_sp_data);
		end else if (push) begin
			sp_next = step_up(sp_reg);
		end else if (pop) begin
			sp_next = step_down(sp_reg);
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sp_reg <= `SPL_SP_RESET;
		end else begin
			sp_reg <= sp_next;
		end
	end

	// The limit is a plain storage register; it gets no reset value.
	always_comb begin
		lim_next = lim_reg;
		if (i_ce && i_lim_wr) begin
			lim_next = word_align(i_lim_data);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		lim_reg <= lim_next;
	end

	// Address on the memory side: write at the pointer, read below it.
	always_comb begin
		o_mem.push_wr = push;
		o_mem.pop_rd  = pop;
		if (pop) begin
			o_mem.addr = step_down(sp_reg);
		end else if (ea_chk) begin
			o_mem.addr = i_req.ea;
		end else begin
			o_mem.addr = sp_reg;
		end
	end

	// A push at the limit itself is allowed, so only addresses above it or below SPL_UNDER_FLOOR trap.
	// The comparison against an unwritten limit may be unknown until set.
	assign chk_addr = o_mem.addr;
	always_comb begin
		o_trap = 1'b0;
		if (push || pop || ea_chk) begin
			if (chk_addr > lim_reg) begin
				o_trap = 1'b1;
			end
			if (chk_addr < `SPL_UNDER_FLOOR) begin
				o_trap = 1'b1;
			end
		end
	end

	assign o_stack_pointer_register = sp_reg;
	assign o_stack_limit_register   = lim_reg;

	// Pointer movement and trap checks.
	a_push_incr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		push && !i_sp_wr |=> sp_reg == $past(sp_reg) + 16'h0002)
		else $error("push did not advance pointer");
	a_pop_decr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pop && !i_sp_wr |=> sp_reg == $past(sp_reg) - 16'h0002)
		else $error("pop did not step pointer back");
	a_pop_addr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pop |-> o_mem.addr == sp_reg - 16'h0002)
		else $error("pop address wrong");
	a_push_addr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		push |-> o_mem.addr == sp_reg)
		else $error("push address wrong");
	a_lim_lsb: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && i_lim_wr |=> o_stack_limit_register[0] == 1'b0)
		else $error("limit bit zero set");
	a_eq_no_trap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		push && sp_reg == lim_reg && sp_reg >= 16'h0800 |-> !o_trap)
		else $error("trap at limit");
	a_over_trap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		push && sp_reg > lim_reg |-> o_trap)
		else $error("overflow not trapped");
	a_under_trap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		ea_chk && i_req.ea < 16'h0800 |-> o_trap)
		else $error("underflow not trapped");
	a_call_msb: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_pc_push && !i_exception |-> o_push_pc_word[7] == 1'b0)
		else $error("call push msb set");
	a_exc_srl: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_pc_push && i_exception |-> o_push_pc_word[15:8] == i_status_low_byte)
		else $error("status byte missing");
	a_no_trap_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!(push || pop || ea_chk) |-> !o_trap)
		else $error("trap without check");

	// Clock enable and register write checks.
	a_ce_freeze: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_ce |=> sp_reg == $past(sp_reg))
		else $error("pointer moved while disabled");
	a_ce_no_trap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_ce |-> !o_trap && !o_mem.push_wr && !o_mem.pop_rd)
		else $error("activity while disabled");
	a_sp_aligned: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		sp_reg[0] == 1'h0)
		else $error("pointer not word aligned");
	a_sp_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && i_sp_wr |=> sp_reg == {$past(i_sp_data[15:1]), 1'h0})
		else $error("pointer write lost");
	a_lim_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_ce && i_lim_wr |=> lim_reg[15:1] == $past(i_lim_data[15:1]))
		else $error("limit write lost");

	// Memory side strobes and address checks.
	a_push_flags: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		push |-> o_mem.push_wr && !o_mem.pop_rd)
		else $error("push strobes wrong");
	a_pop_flags: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pop |-> o_mem.pop_rd && !o_mem.push_wr)
		else $error("pop strobes wrong");
	a_ea_addr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		ea_chk |-> o_mem.addr == i_req.ea)
		else $error("checked address wrong");
	a_ea_over: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		ea_chk && i_req.ea > lim_reg |-> o_trap)
		else $error("address above limit not trapped");

	// Underflow, in-range and pushed word checks.
	a_pop_under: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pop && sp_reg == 16'h0800 |-> o_trap)
		else $error("pop below floor not trapped");
	a_push_under: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		push && sp_reg < 16'h0800 |-> o_trap)
		else $error("push below floor not trapped");
	a_in_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(push || pop || ea_chk) && chk_addr >= 16'h0800 && chk_addr <= lim_reg |-> !o_trap)
		else $error("trap inside the allowed range");
	a_call_word: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_pc_push && !i_exception |-> o_push_pc_word == {9'h000, i_pc_hi[6:0]})
		else $error("call push word wrong");
	a_exc_pc_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_pc_push && i_exception |-> o_push_pc_word[7:0] == i_pc_hi)
		else $error("exception push lost pc bits");

	c_push: cover property (@(posedge i_clk_sys) disable iff (i_rst) push);
	c_pop: cover property (@(posedge i_clk_sys) disable iff (i_rst) pop);
	c_trap: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_trap);
	c_exc: cover property (@(posedge i_clk_sys) disable iff (i_rst) i_pc_push && i_exception);
	c_at_limit: cover property (@(posedge i_clk_sys) disable iff (i_rst) push && sp_reg == lim_reg);
endmodule

/* File: hw/spl_consts.svh */
// Constants for the stack pointer limit check block.
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH
`define SPL_DATA_W      16
`define SPL_UNDER_FLOOR 16'h0800
`define SPL_WORD_STEP   16'h0002
`define SPL_SP_RESET    16'h0800
`define SPL_PC_HI_MSB   7
`endif

/* File: hw/spl_pkg.sv */
// Types shared by the stack pointer limit check block.
package spl_pkg;
	typedef enum logic [3:0] {
		SPL_OP_NONE = 4'h1,
		SPL_OP_PUSH = 4'h2,
		SPL_OP_POP  = 4'h4,
		SPL_OP_EA   = 4'h8
	} spl_op_e;

	typedef struct packed {
		logic        valid;
		spl_op_e     op;
		logic [15:0] ea;
	} spl_req_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        pop_rd;
		logic        push_wr;
	} spl_mem_s;
endpackage

/* File: hw/spl_pc_format.sv */
// Formats the upper program counter word pushed on calls and exceptions.
`timescale 1ns/1ps
`include "spl_consts.svh"
module spl_pc_format
	import spl_pkg::*;
(
	input  wire logic [7:0]  i_pc_hi,
	input  wire logic        i_exception,
	input  wire logic [7:0]  i_status_low_byte,
	output logic      [15:0] o_word
);
	always_comb begin
		if (i_exception) begin
			o_word = {i_status_low_byte, i_pc_hi};
		end else begin
			o_word = {8'h00, 1'b0, i_pc_hi[`SPL_PC_HI_MSB-1:0]};
		end
	end
endmodule

/* File: tb/spl_core_model.sv */
// Core address generator model that issues stack requests to the block.
`timescale 1ns/1ps
module spl_core_model
	import spl_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_lim_wr,
	input  wire spl_op_e     i_op,
	input  wire logic [15:0] i_ea,
	output spl_req_s         o_req
);
	logic lim_wr_reg = 1'b0;
	always @(posedge i_clk_sys) lim_wr_reg <= i_lim_wr;
	// Valid is withheld in the cycle after a limit write; the limit register already holds the new value by then.
	assign o_req = '{valid: i_op != SPL_OP_NONE && !lim_wr_reg, op: i_op, ea: i_ea};
endmodule

/* File: tb/stack_pointer_limit_check_test.sv */
// Self-checking bench for the stack pointer limit check block.
`timescale 1ns/1ps
module stack_pointer_limit_check_test;
	import spl_pkg::*;
	logic        clk = 0, rst = 1, ce = 1, pc_push = 0, exc = 0, lim_wr = 0, sp_wr = 0;
	logic [7:0]  pc_hi = 0, status_low_byte = 0;
	logic [15:0] lim_d = 0, sp_d = 0, ea = 0, sp, lim, pcw;
	spl_op_e     op = SPL_OP_NONE;
	spl_req_s    req;
	spl_mem_s    mem;
	logic        trap;
	logic [18:0] exp_q[$];
	int          failures = 0, comparisons = 0, cyc = 0;
	spl_core_model u_core(.i_clk_sys(clk), .i_lim_wr(lim_wr), .i_op(op), .i_ea(ea), .o_req(req));
	spl_stack_check u_dut(.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_req(req),
		.i_pc_push(pc_push), .i_exception(exc), .i_pc_hi(pc_hi), .i_status_low_byte(status_low_byte),
		.i_lim_wr(lim_wr), .i_lim_data(lim_d), .i_sp_wr(sp_wr), .i_sp_data(sp_d),
		.o_stack_pointer_register(sp), .o_stack_limit_register(lim), .o_mem(mem),
		.o_push_pc_word(pcw), .o_trap(trap));
	task automatic check(input logic [18:0] seen, input logic [18:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// The caller clears op itself so a signal is never driven twice in one time step.
	task automatic step(input spl_op_e o, input logic [15:0] a, input logic [18:0] e);
		op = o;
		ea = a;
		if (o != SPL_OP_NONE) exp_q.push_back(e);
		@(posedge clk) #1;
	endtask
	initial forever #20 clk = ~clk;
	always @(negedge clk) if (req.valid === 1'b1 && exp_q.size() > 0) begin
		check({mem, trap}, exp_q.pop_front());
	end
	always @(posedge clk) if (++cyc > 400) begin
		failures++;
		stop_test();
	end
	initial begin
		logic [15:0] s;
		void'($urandom(61));
		repeat (2) @(posedge clk);
		#1 rst = 0;
		check({3'b0, lim}, 19'h0XXXX);
		check({3'b0, sp}, 19'h00800);
		lim_wr = 1;
		lim_d = 16'h0805;
		@(posedge clk) #1;
		lim_wr = 0;
		check({3'b0, lim}, 19'h00804);
		// The core keeps stack accesses off the cycle after a limit write.
		@(posedge clk) #1;
		pc_push = 1;
		for (int i = 0; i < 4; i++) begin
			s = 16'h0800 + 16'(2 * i);
			pc_hi = 8'($urandom);
			status_low_byte = 8'($urandom);
			exc = i[0];
			op = SPL_OP_PUSH;
			#1 check({3'b0, pcw}, exc ? {3'b0, status_low_byte, pc_hi} : {12'h000, pc_hi[6:0]});
			step(SPL_OP_PUSH, 16'h0000, {s, 2'b01, s > 16'h0804});
			if (i < 3) check({3'b0, sp}, {3'b0, s + 16'h0002});
		end
		pc_push = 0;
		op = SPL_OP_NONE;
		sp_wr = 1;
		sp_d = 16'h0803;
		@(posedge clk) #1;
		sp_wr = 0;
		check({3'b0, sp}, 19'h00802);
		step(SPL_OP_POP, 16'h0000, {16'h0800, 2'b10, 1'b0});
		check({3'b0, sp}, 19'h00800);
		step(SPL_OP_POP, 16'h0000, {16'h07FE, 2'b10, 1'b1});
		ce = 0;
		step(SPL_OP_PUSH, 16'h0000, {16'h07FE, 2'b00, 1'b0});
		ce = 1;
		check({3'b0, sp}, 19'h007FE);
		step(SPL_OP_PUSH, 16'h0000, {16'h07FE, 2'b01, 1'b1});
		check({3'b0, sp}, 19'h00800);
		for (int i = 0; i < 8; i++) begin
			s = 16'h0700 + 16'($urandom_range(0, 255)) * 16'h0002;
			step(SPL_OP_EA, s, {s, 2'b00, s > 16'h0804 || s < 16'h0800});
		end
		step(SPL_OP_PUSH, 16'h0000, {16'h0800, 2'b01, 1'b0});
		op = SPL_OP_NONE;
		rst = 1;
		@(posedge clk) #1;
		rst = 0;
		check({3'b0, sp}, 19'h00800);
		check({18'h00000, exp_q.size() == 0}, 19'h00001);
		stop_test();
	end
endmodule
